/* core/sdgcr_pkg.sv */
// Constants and encodings shared by the configuration register block
package sdgcr_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned PAYLOAD_W  = 16;
  localparam int unsigned CMD_W      = 7;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned DIR_BIT    = 23;
  localparam int unsigned CMD_HI     = 22;
  localparam int unsigned CMD_LO     = 16;
  localparam int unsigned CODE_HI    = 11;
  localparam int unsigned CODE_LO    = 2;
  localparam int unsigned FLAG_BIT   = 0;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CMD_OUT_ENABLE = 7'h18;
  localparam logic [6:0] CMD_BROADCAST  = 7'h19;
  localparam logic [6:0] CMD_READY_CTL  = 7'h1e;
  localparam logic [6:0] CMD_PIN_DIR    = 7'h1f;
  localparam logic [6:0] CMD_STATUS     = 7'h20;
  localparam logic [6:0] CMD_PIN_INPUT  = 7'h30;
  localparam logic [6:0] CMD_PIN_OUTPUT = 7'h31;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH  = 4;
  localparam int unsigned CODE_W  = 10;
  localparam int unsigned GPIO_W  = 12;
  localparam int unsigned START_W = 13;

  // ----------------------------------------------------------------
  // Values after reset and counts
  // ----------------------------------------------------------------
  localparam logic [3:0]  RST_ENABLE_MASK = 4'h0;
  localparam logic [9:0]  RST_CODE        = 10'h000;
  localparam logic        RST_READY_CTL   = 1'b0;
  localparam logic [11:0] RST_PIN_DIR     = 12'h000;
  localparam logic [11:0] RST_PIN_OUTPUT  = 12'h000;
  localparam int unsigned STARTUP_CYCLES  = 16;
  localparam int unsigned STARTUP_MAX     = 4096;

endpackage : sdgcr_pkg

/* core/sdgcr_top.sv */
// Serial-framed configuration and status registers for outputs and GPIO
//
// Contract
// - Bit 23 direction, bits 22:16 command code
// - Next frame echoes command, payload read data
// - Output enable mask at code 0011000, bits 3:0
// - Mask bit one enables matching analog output
// - Broadcast code 0011001 write-only, code bits 11:2
// - Broadcast loads all four channel registers together
// - Ready pin control bit at code 0011110
// - Control bit one disables ready pin function
// - Enabled ready pin flags new conversion data
// - Pin direction word at code 0011111, bits 11:0
// - Direction bit one makes pin an output
// - Status read-only at code 0100000, bit 0
// - Ready flag set after power-on, one means ready
// - Code 0110000 reports all pin levels always
// - Pin output word at 0110001 drives output pins
`timescale 1ns/1ps
`default_nettype none

module sdgcr_top #(
  parameter int unsigned STARTUP = sdgcr_pkg::STARTUP_CYCLES
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  rstn,
  input  wire logic                                  ce,
  input  wire logic                                  sclk,
  input  wire logic                                  csN,
  input  wire logic                                  mosi,
  output var  logic                                  miso,
  output var  logic                                  misoOe,
  input  wire logic                                  convDone,
  output var  logic                                  convReadyN,
  input  wire logic [sdgcr_pkg::GPIO_W-1:0]          gpioIn,
  output var  logic [sdgcr_pkg::GPIO_W-1:0]          gpioOut,
  output var  logic [sdgcr_pkg::GPIO_W-1:0]          gpioOe,
  output var  logic [sdgcr_pkg::NUM_CH-1:0]          dacEnable,
  output var  logic [sdgcr_pkg::NUM_CH-1:0]
                    [sdgcr_pkg::CODE_W-1:0]          dacCode,
  output var  logic                                  dacLoad
);
  import sdgcr_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (STARTUP < 1 || STARTUP > STARTUP_MAX) begin : g_bad_startup
    $error("STARTUP must lie between 1 and 4096");
  end

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0]       cnt;
    logic [FRAME_BITS-2:0]  shift;
  } sdgcr_frame_t;

  typedef struct packed {
    logic [FRAME_BITS-1:0]  word;
    logic                   tgl;
  } sdgcr_hold_t;

  typedef struct packed {
    logic [NUM_CH-1:0]              enableMask;
    logic [NUM_CH-1:0][CODE_W-1:0]  chanCode;
    logic                           chanLoad;
    logic                           readyCtl;
    logic [GPIO_W-1:0]              pinDir;
    logic [GPIO_W-1:0]              pinOut;
    logic [GPIO_W-1:0]              gpiS1;
    logic [GPIO_W-1:0]              gpiS2;
    logic                           ready;
    logic [START_W-1:0]             startCnt;
    logic [2:0]                     csS;
    logic [2:0]                     sckS;
    logic [2:0]                     tgS;
    logic [FRAME_BITS-1:0]          resp;
    logic [FRAME_BITS-1:0]          tx;
    logic                           dout;
    logic                           doutEn;
    logic                           convReadyN;
  } sdgcr_core_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic sdgcr_core_t coreReset();
    sdgcr_core_t r;
    r            = '0;
    r.enableMask = RST_ENABLE_MASK;
    for (int i = 0; i < NUM_CH; i++) begin
      r.chanCode[i] = RST_CODE;
    end
    r.readyCtl   = RST_READY_CTL;
    r.pinDir     = RST_PIN_DIR;
    r.pinOut     = RST_PIN_OUTPUT;
    r.csS        = 3'h7;
    r.sckS       = 3'h7;
    r.convReadyN = 1'b1;
    return r;
  endfunction

  // Read payload for a command; unknown and write-only codes read zero
  function automatic logic [PAYLOAD_W-1:0] readValue(
    input logic [CMD_W-1:0] cmd,
    input sdgcr_core_t      s
  );
    logic [PAYLOAD_W-1:0] v;
    v = '0;
    case (cmd)
      CMD_OUT_ENABLE: v[NUM_CH-1:0] = s.enableMask;
      CMD_READY_CTL:  v[FLAG_BIT]   = s.readyCtl;
      CMD_PIN_DIR:    v[GPIO_W-1:0] = s.pinDir;
      CMD_STATUS:     v[FLAG_BIT]   = s.ready;
      CMD_PIN_INPUT:  v[GPIO_W-1:0] = s.gpiS2;
      CMD_PIN_OUTPUT: v[GPIO_W-1:0] = s.pinOut;
      default:        v             = '0;
    endcase
    return v;
  endfunction

  localparam sdgcr_core_t CORE_RST = coreReset();

  // ----------------------------------------------------------------
  // Link domain: frame receive on falling serial clock edges
  // ----------------------------------------------------------------
  // Chip select clears the bit counter asynchronously, so an aborted
  // frame never leaves a stale count for the next one.
  sdgcr_frame_t qf;
  sdgcr_frame_t next_qf;
  sdgcr_hold_t  qh;
  sdgcr_hold_t  next_qh;
  logic         linkRstN;

  assign linkRstN = rstn & ~csN;

  always_comb begin
    next_qf = qf;
    next_qh = qh;
    if (qf.cnt < CNT_W'(FRAME_BITS)) begin
      next_qf.cnt   = qf.cnt + 1'b1;
      next_qf.shift = {qf.shift[FRAME_BITS-3:0], mosi};
    end
    // Word stays put until the next full frame, so the core reads it
    // safely once the toggle has crossed
    if (qf.cnt == CNT_W'(FRAME_BITS - 1)) begin
      next_qh.word = {qf.shift, mosi};
      next_qh.tgl  = ~qh.tgl;
    end
  end

  always_ff @(negedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      qf <= '0;
    end else begin
      qf <= next_qf;
    end
  end

  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      qh <= '0;
    end else begin
      qh <= next_qh;
    end
  end

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  sdgcr_core_t q;
  sdgcr_core_t next_q;
  logic        frameEv;
  logic        csFall;
  logic        csRise;
  logic        sckRise;
  logic [CMD_W-1:0]     rxCmd;
  logic [PAYLOAD_W-1:0] rxPay;
  logic                 rxRead;

  assign frameEv = q.tgS[2] ^ q.tgS[1];
  assign csFall  = q.csS[2] & ~q.csS[1];
  assign csRise  = ~q.csS[2] & q.csS[1];
  // The serial clock idles high, so the first rising edge seen inside
  // a frame follows the first sampling edge
  assign sckRise = q.sckS[1] & ~q.sckS[2] & ~q.csS[1];
  assign rxRead  = qh.word[DIR_BIT];
  assign rxCmd   = qh.word[CMD_HI:CMD_LO];
  assign rxPay   = qh.word[PAYLOAD_W-1:0];

  always_comb begin
    next_q          = q;
    next_q.chanLoad = 1'b0;
    next_q.gpiS1    = gpioIn;
    next_q.gpiS2    = q.gpiS1;
    next_q.csS      = {q.csS[1:0], csN};
    next_q.sckS     = {q.sckS[1:0], sclk};
    next_q.tgS      = {q.tgS[1:0], qh.tgl};

    // Ready flag rises a fixed time after reset release
    if (!q.ready) begin
      if (q.startCnt == START_W'(STARTUP - 1)) begin
        next_q.ready = 1'b1;
      end else begin
        next_q.startCnt = q.startCnt + 1'b1;
      end
    end

    if (frameEv) begin
      if (!rxRead) begin
        case (rxCmd)
          CMD_OUT_ENABLE: next_q.enableMask = rxPay[NUM_CH-1:0];
          CMD_BROADCAST: begin
            for (int i = 0; i < NUM_CH; i++) begin
              next_q.chanCode[i] = rxPay[CODE_HI:CODE_LO];
            end
            next_q.chanLoad = 1'b1;
          end
          CMD_READY_CTL:  next_q.readyCtl = rxPay[FLAG_BIT];
          CMD_PIN_DIR:    next_q.pinDir   = rxPay[GPIO_W-1:0];
          CMD_PIN_OUTPUT: next_q.pinOut   = rxPay[GPIO_W-1:0];
          default: begin
          end
        endcase
      end
      // Writes answer with a zero payload
      next_q.resp = {qh.word[DIR_BIT:CMD_LO],
                     rxRead ? readValue(rxCmd, q) : 16'h0000};
    end

    // Transmit side oversamples the serial clock; a reply is latched
    // at frame start, so the host must leave a gap between frames
    if (csFall) begin
      next_q.tx     = next_q.resp;
      next_q.dout   = next_q.resp[FRAME_BITS-1];
      next_q.doutEn = 1'b1;
    end else if (sckRise) begin
      next_q.tx   = {q.tx[FRAME_BITS-2:0], 1'b0};
      next_q.dout = q.tx[FRAME_BITS-2];
    end
    if (csRise) begin
      next_q.doutEn = 1'b0;
      next_q.dout   = 1'b0;
    end

    // Pin stays low from new data until the host opens a frame; a new
    // event in the same cycle beats the release
    if (csFall) begin
      next_q.convReadyN = 1'b1;
    end
    if (convDone && !next_q.readyCtl) begin
      next_q.convReadyN = 1'b0;
    end
    if (next_q.readyCtl) begin
      next_q.convReadyN = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= CORE_RST;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign miso       = q.dout;
  assign misoOe     = q.doutEn;
  assign convReadyN = q.convReadyN;
  assign gpioOut    = q.pinOut;
  assign gpioOe     = q.pinDir;
  assign dacEnable  = q.enableMask;
  assign dacCode    = q.chanCode;
  assign dacLoad    = q.chanLoad;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_echo;
    frameEv && ce |=> q.resp[FRAME_BITS-1:CMD_LO] ==
                      $past(qh.word[FRAME_BITS-1:CMD_LO]);
  endproperty
  a_echo: assert property (p_echo)
    else $error("reply does not echo the command");
  property p_write_zero;
    frameEv && ce && !rxRead |=> q.resp[PAYLOAD_W-1:0] == 16'h0000;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("write reply payload is not zero");
  property p_mask;
    frameEv && ce && !rxRead && rxCmd == CMD_OUT_ENABLE
      |=> dacEnable == $past(rxPay[NUM_CH-1:0]);
  endproperty
  a_mask: assert property (p_mask)
    else $error("enable mask not loaded");
  property p_broadcast;
    frameEv && ce && !rxRead && rxCmd == CMD_BROADCAST
      |=> dacLoad && dacCode[0] == $past(rxPay[CODE_HI:CODE_LO])
          && dacCode[3] == dacCode[0] && dacCode[1] == dacCode[2]
          && dacCode[1] == dacCode[0] ##1 !dacLoad || !ce;
  endproperty
  a_broadcast: assert property (p_broadcast)
    else $error("broadcast did not load all channels");
  property p_bcast_read;
    frameEv && ce && rxRead && rxCmd == CMD_BROADCAST
      |=> q.resp[PAYLOAD_W-1:0] == 16'h0000 && !dacLoad;
  endproperty
  a_bcast_read: assert property (p_bcast_read)
    else $error("broadcast code answered a read");
  property p_ready_ctl;
    frameEv && ce && !rxRead && rxCmd == CMD_READY_CTL
      |=> q.readyCtl == $past(rxPay[FLAG_BIT]);
  endproperty
  a_ready_ctl: assert property (p_ready_ctl)
    else $error("ready control bit not loaded");
  property p_pin_off;
    q.readyCtl |-> convReadyN;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("ready pin asserted while disabled");
  property p_conv;
    convDone && ce && !q.readyCtl && !(frameEv && !rxRead &&
      rxCmd == CMD_READY_CTL) |=> !convReadyN;
  endproperty
  a_conv: assert property (p_conv)
    else $error("ready pin missed new conversion data");
  property p_dir;
    frameEv && ce && !rxRead && rxCmd == CMD_PIN_DIR
      |=> gpioOe == $past(rxPay[GPIO_W-1:0]);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction word not applied");
  property p_status;
    frameEv && ce && rxRead && rxCmd == CMD_STATUS
      |=> q.resp[PAYLOAD_W-1:0] == {15'h0000, $past(q.ready)};
  endproperty
  a_status: assert property (p_status)
    else $error("status reply wrong");
  property p_gpi;
    frameEv && ce && rxRead && rxCmd == CMD_PIN_INPUT
      |=> q.resp[PAYLOAD_W-1:0] == {4'h0, $past(q.gpiS2)};
  endproperty
  a_gpi: assert property (p_gpi)
    else $error("pin state reply wrong");
  property p_gpo;
    frameEv && ce && !rxRead && rxCmd == CMD_PIN_OUTPUT
      |=> gpioOut == $past(rxPay[GPIO_W-1:0]);
  endproperty
  a_gpo: assert property (p_gpo)
    else $error("pin output word not applied");

endmodule : sdgcr_top

`default_nettype wire

/* test/sdgcr_host_model.sv */
// Serial host model that sends request frames and collects replies
`timescale 1ns/1ps
`default_nettype none

module sdgcr_host_model #(
  parameter int HALF_NS = 40,
  // Offset keeps link edges off the core clock edges
  parameter int SKEW_NS = 3
) (
  output var  logic sclk,
  output var  logic csN,
  output var  logic mosi,
  input  wire logic miso
);

  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    mosi = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame: clock stands high outside frames
  // ----------------------------------------------------------------
  // Reply bits are taken at falling edges, a half period after the
  // rising edge that launched them, leaving room for the core sync delay
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    xferN(tx, 24, rx);
  endtask

  // Frame of n bits; fewer than 24 leaves a cut frame to be dropped
  task automatic xferN(input logic [23:0] tx, input int n,
                       output logic [23:0] rx);
    rx   = '0;
    #(SKEW_NS);
    csN  = 1'b0;
    mosi = tx[23];
    #(HALF_NS);
    for (int i = 23; i >= 24 - n; i--) begin
      rx[i] = miso;
      sclk  = 1'b0;
      #(HALF_NS);
      sclk  = 1'b1;
      if (i > 0) begin
        mosi = tx[i-1];
      end
      #(HALF_NS);
    end
    #(HALF_NS);
    csN  = 1'b1;
    // Released line shows the inverse so a stale level cannot pass
    mosi = ~mosi;
    // Select high long enough for the reply to be latched; the whole
    // frame stays a multiple of the core period so the offset holds
    #(3 * HALF_NS - SKEW_NS);
  endtask

endmodule // sdgcr_host_model
`default_nettype wire

/* test/tb_spi_dac_gpio_config_regs.sv */
// Self-checking bench for the serial configuration register block
`timescale 1ns/1ps
`default_nettype none

module tb_spi_dac_gpio_config_regs;
  import sdgcr_pkg::*;

  typedef struct packed {
    logic [23:0] tx;
    logic [15:0] pay;
  } sdgcr_row_t;

  localparam logic RD = 1'b1;
  localparam logic WR = 1'b0;

  logic                          core_clk = 1'b0;
  logic                          rstn;
  logic                          ce;
  logic                          convDone;
  logic [GPIO_W-1:0]             extPins;
  logic                          sclk;
  logic                          csN;
  logic                          mosi;
  logic                          miso;
  logic                          misoOe;
  logic                          convReadyN;
  logic                          dacLoad;
  logic [GPIO_W-1:0]             gpioIn;
  logic [GPIO_W-1:0]             gpioOut;
  logic [GPIO_W-1:0]             gpioOe;
  logic [NUM_CH-1:0]             dacEnable;
  logic [NUM_CH-1:0][CODE_W-1:0] dacCode;
  logic [23:0]                   rx;
  int                            errorCnt = 0;
  int                            samplesChecked = 0;
  int                            loadCnt = 0;
  int                            cycles = 0;
  int                            oeLag = 0;
  sdgcr_row_t                    rows [14];

  always #4 core_clk = ~core_clk;

  // Pin level: driven bits follow the device, the rest the outside world
  assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & extPins);

  sdgcr_top #(.STARTUP(1000)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .sclk(sclk),
    .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe),
    .convDone(convDone), .convReadyN(convReadyN), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .dacEnable(dacEnable),
    .dacCode(dacCode), .dacLoad(dacLoad)
  );

  sdgcr_host_model host_u (
    .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso)
  );

  function automatic logic [23:0] fr(input logic rd, input logic [6:0] c,
                                     input logic [15:0] p);
    return {rd, c, p};
  endfunction

  task automatic chk(input string name, input logic [39:0] exp,
                     input logic [39:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      errorCnt++;
    end
  endtask

  task automatic pulseDone();
    @(posedge core_clk);
    convDone <= 1'b1;
    @(posedge core_clk);
    convDone <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 5500 cycles the sequence needs
  always @(posedge core_clk) begin
    cycles++;
    if (dacLoad === 1'b1) begin
      loadCnt++;
    end
    if (cycles == 20000) begin
      errorCnt++;
      completeRun();
    end
  end

  // Output enable must follow the select within the sync delay
  always @(posedge core_clk) begin
    oeLag = (misoOe !== ~csN) ? oeLag + 1 : 0;
    if (oeLag == 5) begin
      chk("output enable", {39'h0, ~csN}, {39'h0, misoOe});
    end
  end

  initial begin
    rstn     <= 1'b0;
    ce       <= 1'b1;
    convDone <= 1'b0;
    extPins  <= 12'h333;
    rows = '{
      '{fr(WR, CMD_OUT_ENABLE, 16'h0005), 16'h0000},
      '{fr(RD, CMD_OUT_ENABLE, 16'h0000), 16'h0005},
      '{fr(WR, CMD_PIN_DIR, 16'h00f0), 16'h0000},
      '{fr(WR, CMD_PIN_OUTPUT, 16'h0a5c), 16'h0000},
      '{fr(RD, CMD_PIN_OUTPUT, 16'h0000), 16'h0a5c},
      '{fr(RD, CMD_PIN_DIR, 16'h0000), 16'h00f0},
      '{fr(RD, CMD_PIN_INPUT, 16'h0000),
        {4'h0, (12'h0f0 & 12'ha5c) | (~12'h0f0 & 12'h333)}},
      '{fr(RD, CMD_STATUS, 16'h0000), 16'h0001},
      '{fr(WR, CMD_STATUS, 16'h0000), 16'h0000},
      '{fr(RD, CMD_BROADCAST, 16'h0000), 16'h0000},
      '{fr(WR, CMD_READY_CTL, 16'h0001), 16'h0000},
      '{fr(RD, CMD_READY_CTL, 16'h0000), 16'h0001},
      '{fr(WR, 7'h55, 16'h0000), 16'h0000},
      '{24'h000000, 16'h0000}
    };
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    // ----------------------------------------------------------------
    // Table of frames, each reply checked in the following frame
    // ----------------------------------------------------------------
    for (int i = 0; i < 14; i++) begin
      host_u.xfer(rows[i].tx, rx);
      if (i > 0) begin
        chk("reply", {rows[i-1].tx[23:16], rows[i-1].pay}, rx);
      end
    end
    chk("enable mask", 4'h5, dacEnable);
    chk("direction", 12'h0f0, gpioOe);
    chk("pin output", 12'ha5c, gpioOut);
    chk("no load on read", 0, loadCnt);
    pulseDone();
    chk("ready pin masked", 1'b1, convReadyN);
    // ----------------------------------------------------------------
    // Broadcast at full scale, then the ready pin cycle
    // ----------------------------------------------------------------
    host_u.xfer(fr(WR, CMD_BROADCAST, 16'h0ffc), rx);
    chk("noop reply", 24'h000000, rx);
    chk("all codes", {NUM_CH{10'h3ff}}, dacCode);
    chk("one load", 1, loadCnt);
    host_u.xfer(fr(WR, CMD_READY_CTL, 16'h0000), rx);
    chk("broadcast reply", {WR, CMD_BROADCAST, 16'h0000}, rx);
    pulseDone();
    chk("ready pin set", 1'b0, convReadyN);
    host_u.xfer(24'h000000, rx);
    chk("ready pin freed", 1'b1, convReadyN);
    // Clock enable low: the conversion event must be ignored
    @(posedge core_clk);
    ce <= 1'b0;
    pulseDone();
    chk("frozen ready pin", 1'b1, convReadyN);
    @(posedge core_clk);
    ce <= 1'b1;
    // ----------------------------------------------------------------
    // Second reset: outputs cleared, ready flag low until startup ends
    // ----------------------------------------------------------------
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    chk("reset pins", {2'b00, 1'b1, 29'h0},
        {miso, misoOe, convReadyN, gpioOut, gpioOe, dacEnable, dacLoad});
    chk("reset codes", 40'h0, dacCode);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Cut write of 16 bits must change nothing and leave no reply
    host_u.xferN(fr(WR, CMD_OUT_ENABLE, 16'h000f), 16, rx);
    chk("cut frame mask", 4'h0, dacEnable);
    host_u.xfer(fr(RD, CMD_STATUS, 16'h0000), rx);
    chk("cut frame reply", 24'h000000, rx);
    host_u.xfer(fr(RD, CMD_OUT_ENABLE, 16'h0000), rx);
    chk("status early", {RD, CMD_STATUS, 16'h0000}, rx);
    host_u.xfer(24'h000000, rx);
    chk("mask after reset", {RD, CMD_OUT_ENABLE, 16'h0000}, rx);
    completeRun();
  end

endmodule // tb_spi_dac_gpio_config_regs
`default_nettype wire
